// >>> rtl/lwit_top.sv
`timescale 1ns/100ps
`default_nettype none

module lwit_top #(
    parameter int N_SRC = 8
) (
    // Clock and reset
    input  wire logic               i_mclk,
    input  wire logic               i_rst,
    // Wishbone slave
    input  wire logic               i_wb_cyc,
    input  wire logic               i_wb_stb,
    input  wire logic               i_wb_we,
    input  wire logic [7:0]         i_wb_adr,
    input  wire logic [3:0]         i_wb_sel,
    input  wire logic [31:0]        i_wb_dat,
    output logic [31:0]             o_wb_dat,
    output logic                    o_wb_ack,
    // Core and interrupt controller
    input  wire lwit_pkg::lwit_twr_s i_twr,
    input  wire logic [N_SRC-1:0]   i_irq_flag,
    // Results
    output logic                    o_stall,
    output lwit_pkg::lwit_prog_s    o_prog,
    output logic                    o_resume,
    output logic                    o_vec_high,
    output logic                    o_vec_low
);
    import lwit_pkg::*;

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (N_SRC < 1 || N_SRC > 32) begin : g_bad_nsrc
        $error("N_SRC must be 1 to 32");
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    lwit_state_e        state;
    lwit_exit_e         last_exit;
    logic               lwe;
    logic               ghigh;
    logic               plow;
    logic [N_SRC-1:0]   src_en;
    logic [N_SRC-1:0]   src_prio;
    logic [7:0]         hold;
    logic               ack;
    logic [31:0]        rdata;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire        req_w    = i_wb_cyc & i_wb_stb & ~ack;
    // Write lands at the ack edge, while the master still holds its data
    wire        wr_w     = i_wb_cyc & i_wb_stb & i_wb_we & ack;
    wire        sel_ctrl = (i_wb_adr == LWIT_OFS_CTRL);
    wire        sel_en   = (i_wb_adr == LWIT_OFS_SRC_EN);
    wire        sel_prio = (i_wb_adr == LWIT_OFS_PRIO);
    wire        sel_stat = (i_wb_adr == LWIT_OFS_STATUS);
    wire [31:0] bmask_w  = {{8{i_wb_sel[3]}}, {8{i_wb_sel[2]}},
                            {8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};
    wire [31:0] en_ext   = 32'(src_en);
    wire [31:0] prio_ext = 32'(src_prio);
    wire [31:0] en_new   = (en_ext & ~bmask_w) | (i_wb_dat & bmask_w);
    wire [31:0] prio_new = (prio_ext & ~bmask_w) | (i_wb_dat & bmask_w);
    wire        ctrl_wr  = wr_w & sel_ctrl & i_wb_sel[0];

    // Read mux; unmapped addresses read zero and still ack
    wire [31:0] stat_w;
    assign stat_w = {16'h0000, hold, 5'h00, last_exit, (state == LWIT_PROG)};
    wire [31:0] ctrl_rd = {29'h0, plow, ghigh, lwe};
    wire [31:0] next_rdata = sel_ctrl ? ctrl_rd :
                             sel_en   ? en_ext  :
                             sel_prio ? prio_ext :
                             sel_stat ? stat_w  : 32'h0000_0000;

    // ------------------------------------------------------------
    // Termination decision
    // ------------------------------------------------------------
    logic hit;
    logic to_high;
    logic to_low;

    lwit_decide #(
        .N_SRC     (N_SRC)
    ) u_decide (
        .i_flag    (i_irq_flag),
        .i_en      (src_en),
        .i_prio    (src_prio),
        .i_ghigh   (ghigh),
        .i_plow    (plow),
        .o_hit     (hit),
        .o_to_high (to_high),
        .o_to_low  (to_low)
    );

    wire busy_w   = (state == LWIT_PROG);
    wire end_w    = busy_w & hit;
    wire start_w  = ~busy_w & i_twr.valid & i_twr.addr0 & lwe;
    wire latch_w  = ~busy_w & i_twr.valid & ~start_w;
    wire lwe_set  = ctrl_wr & i_wb_dat[LWIT_CTRL_LWE_BIT];
    lwit_exit_e next_exit;
    assign next_exit = to_high ? LWIT_EXIT_HIGH :
                       to_low  ? LWIT_EXIT_LOW  :
                                 LWIT_EXIT_NEXT;

    // ------------------------------------------------------------
    // Bus registers
    // ------------------------------------------------------------
    // Long-write enable can only be set; only reset clears it
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            ack   <= 1'b0;
            rdata <= 32'h0000_0000;
            lwe   <= LWIT_RST_LWE;
            ghigh <= LWIT_RST_GHIGH;
            plow  <= LWIT_RST_PLOW;
        end else begin
            ack   <= req_w;
            rdata <= req_w ? next_rdata : 32'h0000_0000;
            lwe   <= lwe | lwe_set;
            if (ctrl_wr) begin
                ghigh <= i_wb_dat[LWIT_CTRL_GHIGH_BIT];
                plow  <= i_wb_dat[LWIT_CTRL_PLOW_BIT];
            end
        end
    end

    // Per-source enables and priorities
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            src_en   <= '0;
            src_prio <= '0;
        end else begin
            if (wr_w & sel_en)   src_en   <= en_new[N_SRC-1:0];
            if (wr_w & sel_prio) src_prio <= prio_new[N_SRC-1:0];
        end
    end

    // ------------------------------------------------------------
    // Long write sequencer
    // ------------------------------------------------------------
    // Flags are only read, never cleared here: software owns them
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            state      <= LWIT_IDLE;
            last_exit  <= LWIT_EXIT_NONE;
            hold       <= LWIT_RST_HOLD;
            o_prog     <= '0;
            o_resume   <= 1'b0;
            o_vec_high <= 1'b0;
            o_vec_low  <= 1'b0;
        end else begin
            o_prog.start <= start_w;
            o_resume     <= end_w & (next_exit == LWIT_EXIT_NEXT);
            o_vec_high   <= end_w & (next_exit == LWIT_EXIT_HIGH);
            o_vec_low    <= end_w & (next_exit == LWIT_EXIT_LOW);
            if (latch_w) begin
                hold <= i_twr.data;
            end
            if (start_w) begin
                o_prog.word <= {i_twr.data, hold};
                state       <= LWIT_PROG;
            end else if (end_w) begin
                state     <= LWIT_IDLE;
                last_exit <= next_exit;
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign o_stall  = busy_w;
    assign o_wb_ack = ack;
    assign o_wb_dat = rdata;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);

    keep_running_a: assert property (busy_w && !hit |=> o_stall)
        else $error("long write stopped without a qualifying flag");
    flag_ends_a: assert property (busy_w && hit |=> !o_stall)
        else $error("qualifying flag did not end long write");
    only_cause_a: assert property ($fell(busy_w) && !$past(i_rst) |-> $past(hit))
        else $error("long write ended without cause");
    later_flag_a: assert property (busy_w && !hit ##1 hit |=> !o_stall)
        else $error("late flag did not resume");
    odd_start_a: assert property (start_w |=> o_stall && o_prog.start)
        else $error("odd table write did not start long write");
    short_only_a: assert property (latch_w |=> !o_stall && !o_prog.start)
        else $error("latch-only write started programming");
    next_instr_a: assert property (end_w && !to_high && !to_low |=> o_resume)
        else $error("missing resume at next instruction");
    low_vector_a: assert property (end_w && !ghigh && plow && !(|(i_irq_flag & src_en & src_prio))
                                   |=> o_vec_low && !o_vec_high)
        else $error("missing low vector");
    high_vector_a: assert property (end_w && ghigh && !plow && (|(i_irq_flag & src_en & src_prio))
                                    |=> o_vec_high && !o_vec_low)
        else $error("missing high vector");
    single_exit_a: assert property (!o_stall && $past(o_stall) && !$past(i_rst)
                                    |-> $onehot({o_resume, o_vec_high, o_vec_low}))
        else $error("exit not exactly one path");

    cov_high_c: cover property (start_w ##[1:20] o_vec_high);
    cov_low_c:  cover property (start_w ##[1:20] o_vec_low);
    cov_next_c: cover property (start_w ##[1:20] o_resume);

endmodule // lwit_top

`default_nettype wire

// >>> rtl/lwit_pkg.sv
package lwit_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses, one 32-bit word each)
    // ------------------------------------------------------------
    localparam logic [7:0] LWIT_OFS_CTRL   = 8'h00;
    localparam logic [7:0] LWIT_OFS_SRC_EN = 8'h04;
    localparam logic [7:0] LWIT_OFS_PRIO   = 8'h08;
    localparam logic [7:0] LWIT_OFS_STATUS = 8'h0c;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int LWIT_CTRL_LWE_BIT   = 0;
    localparam int LWIT_CTRL_GHIGH_BIT = 1;
    localparam int LWIT_CTRL_PLOW_BIT  = 2;
    localparam int LWIT_STAT_BUSY_BIT  = 0;
    localparam int LWIT_STAT_EXIT_LSB  = 1;
    localparam int LWIT_STAT_HOLD_LSB  = 8;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic       LWIT_RST_LWE   = 1'b0;
    localparam logic       LWIT_RST_GHIGH = 1'b0;
    localparam logic       LWIT_RST_PLOW  = 1'b0;
    localparam logic [7:0] LWIT_RST_HOLD  = 8'h00;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic {
        LWIT_IDLE = 1'b0,
        LWIT_PROG = 1'b1
    } lwit_state_e;

    typedef enum logic [1:0] {
        LWIT_EXIT_NONE = 2'b00,
        LWIT_EXIT_NEXT = 2'b01,
        LWIT_EXIT_LOW  = 2'b11,
        LWIT_EXIT_HIGH = 2'b10
    } lwit_exit_e;

    // Table write request from the core
    typedef struct packed {
        logic       valid;
        logic       addr0;
        logic [7:0] data;
    } lwit_twr_s;

    // Programming request toward the memory array
    typedef struct packed {
        logic        start;
        logic [15:0] word;
    } lwit_prog_s;

endpackage : lwit_pkg

// >>> rtl/lwit_decide.sv
`timescale 1ns/100ps
`default_nettype none

module lwit_decide #(
    parameter int N_SRC = 8
) (
    // Interrupt controller state
    input  wire logic [N_SRC-1:0] i_flag,
    input  wire logic [N_SRC-1:0] i_en,
    input  wire logic [N_SRC-1:0] i_prio,
    input  wire logic             i_ghigh,
    input  wire logic             i_plow,
    // Decision
    output logic                  o_hit,
    output logic                  o_to_high,
    output logic                  o_to_low
);

    // ------------------------------------------------------------
    // Termination and exit path
    // ------------------------------------------------------------
    wire [N_SRC-1:0] cause_w = i_flag & i_en;     // Priority and globals ignored here
    wire             high_w  = |(cause_w & i_prio);
    wire             low_w   = |(cause_w & ~i_prio);

    // High wins when both levels are pending and both enabled
    assign o_hit     = |cause_w;
    assign o_to_high = i_ghigh & high_w;
    assign o_to_low  = ~o_to_high & i_plow & low_w;

endmodule // lwit_decide

`default_nettype wire

// >>> sim/lwit_core_model.sv
`timescale 1ns/100ps
`default_nettype none
module lwit_core_model #(
    parameter int N_SRC = 8
) (
    // Clock, reset, core halt
    input  wire logic               i_mclk,
    input  wire logic               i_rst,
    input  wire logic               i_stall,
    // Software commands
    input  wire logic               i_go,
    input  wire logic [15:0]        i_word,
    input  wire logic [N_SRC-1:0]   i_set,
    input  wire logic [N_SRC-1:0]   i_clr,
    // Toward the block
    output var lwit_pkg::lwit_twr_s o_twr,
    output logic [N_SRC-1:0]        o_flag
);
    import lwit_pkg::*;
    logic       odd_due;
    logic [7:0] odd_byte;
    // Even byte then odd byte back to back; a halted core starts no new pair
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_twr    <= '0;
            odd_due  <= 1'b0;
            odd_byte <= 8'h00;
        end else if (odd_due) begin
            o_twr   <= '{1'b1, 1'b1, odd_byte};
            odd_due <= 1'b0;
        end else if (i_go && !i_stall) begin
            o_twr    <= '{1'b1, 1'b0, i_word[7:0]};
            odd_due  <= 1'b1;
            odd_byte <= i_word[15:8];
        end else begin
            o_twr <= '{1'b0, 1'b0, ~o_twr.data}; // Idle data toggles, never holds
        end
    end
    // Flags set by events, cleared only by software or reset
    always_ff @(posedge i_mclk) begin
        o_flag <= i_rst ? '0 : (o_flag | i_set) & ~i_clr;
    end
endmodule // lwit_core_model
`default_nettype wire

// >>> sim/test_long_write_interrupt_termination.sv
`timescale 1ns/100ps
`default_nettype none
module test_long_write_interrupt_termination;
    import lwit_pkg::*;
    localparam logic [2:0] ROWS [5] = '{3'b001, 3'b011, 3'b100, 3'b010, 3'b101};
    logic        i_mclk = 1'b0;
    logic        i_rst  = 1'b1;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, go = 1'b0;
    logic [7:0]  adr = 8'h00, set = 8'h00, clr = 8'h00, flag;
    logic [3:0]  sel = 4'hf;
    logic [31:0] wdat = 32'h0, rdat, q, r;
    logic [31:0] seed = 32'h8b4baf72;
    logic [15:0] word = 16'h0;
    logic        ack, stall, resume, vh, vl, gh, pl, pr;
    logic [2:0]  s;
    lwit_twr_s   twr;
    lwit_prog_s  prog;
    lwit_exit_e  ex;
    int          failures = 0, n_tests = 0, i;
    // 25 MHz clock
    always #20 i_mclk = ~i_mclk;
    lwit_top #(.N_SRC(8)) lwit_top_inst (
        .i_mclk(i_mclk), .i_rst(i_rst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
        .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
        .i_twr(twr), .i_irq_flag(flag), .o_stall(stall), .o_prog(prog),
        .o_resume(resume), .o_vec_high(vh), .o_vec_low(vl));
    lwit_core_model #(.N_SRC(8)) lwit_core_model_inst (
        .i_mclk(i_mclk), .i_rst(i_rst), .i_stall(stall), .i_go(go), .i_word(word),
        .i_set(set), .i_clr(clr), .o_twr(twr), .o_flag(flag));
    // Random source and expected exit
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    function automatic lwit_exit_e exp_exit(input logic h, input logic l, input logic p);
        if (h && p) return LWIT_EXIT_HIGH;
        if (l && !p) return LWIT_EXIT_LOW;
        return LWIT_EXIT_NEXT;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Classic single Wishbone cycle; waits for ack, no fixed latency assumed
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        n = 0;
        do begin
            @(posedge i_mclk);
            n++;
        end while (ack !== 1'b1 && n < 16);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 16) begin
            failures++;
            stop_test();
        end
        @(posedge i_mclk);
    endtask
    // Even then odd table write; long tells whether programming must start
    task automatic prog_pair(input logic [15:0] w, input logic long);
        int n;
        go   <= 1'b1;
        word <= w;
        @(posedge i_mclk);
        go <= 1'b0;
        n = 0;
        while (prog.start !== 1'b1 && n < 8) begin
            @(posedge i_mclk);
            n++;
        end
        chk(prog.start, long, "start");
        chk(stall, long, "stall");
        if (long) chk(prog.word, w, "word");
    endtask
    task automatic pulse_flag(input logic [7:0] m, input logic c);
        if (c) clr <= m;
        else set <= m;
        @(posedge i_mclk);
        set <= 8'h00;
        clr <= 8'h00;
    endtask
    // Waits for release, then checks the single exit pulse
    task automatic end_check(input lwit_exit_e e, input int lat);
        int n;
        n = 0;
        while (stall === 1'b1 && n < 8) begin
            @(posedge i_mclk);
            n++;
        end
        if (n >= 8) begin
            failures++;
            stop_test();
        end
        if (lat > 0) chk(n, lat, "release");
        chk({vh, vl, resume}, {e == LWIT_EXIT_HIGH, e == LWIT_EXIT_LOW,
            e == LWIT_EXIT_NEXT}, "exit");
    endtask
    // Main sequence
    initial begin
        repeat (8) @(posedge i_mclk);
        i_rst <= 1'b0;
        @(posedge i_mclk);
        wb(0, LWIT_OFS_STATUS, 0);
        chk(q, 0, "status rst");
        wb(0, 8'h40, 0);
        chk(q, 0, "unmapped");
        prog_pair(16'h5aa5, 0);
        wb(0, LWIT_OFS_STATUS, 0);
        chk(q & 32'hff00, 32'h5a00, "holding");
        for (i = 0; i < 12; i++) begin
            seed = lfsr(seed);
            r = seed;
            s = r[2:0];
            {gh, pl, pr} = (i < 5) ? ROWS[i] : r[5:3];
            wb(1, LWIT_OFS_CTRL, {29'h0, pl, gh, i != 1});
            wb(1, LWIT_OFS_SRC_EN, (i == 0) ? ~(32'h1 << s) : 32'h1 << s);
            wb(1, LWIT_OFS_PRIO, pr ? 32'h1 << s : ~(32'h1 << s));
            prog_pair(r[31:16], 1);
            repeat (4) @(posedge i_mclk);
            chk(stall, 1, "no flag");
            pulse_flag(8'h1 << s, 0);
            if (i == 0) begin
                repeat (4) @(posedge i_mclk);
                chk(stall, 1, "disabled");
                wb(1, LWIT_OFS_SRC_EN, 32'h1 << s);
            end
            ex = exp_exit(gh, pl, pr);
            end_check(ex, (i == 0) ? 0 : 2);
            wb(0, LWIT_OFS_STATUS, 0);
            chk(q & 32'h7, {ex, 1'b0}, "status");
            pulse_flag(8'h1 << s, 1);
            $display("test %0d done", i);
        end
        prog_pair(16'hc33c, 1);
        i_rst <= 1'b1;
        repeat (2) @(posedge i_mclk);
        i_rst <= 1'b0;
        @(posedge i_mclk);
        chk({stall, vh, vl, resume}, 0, "reset end");
        wb(0, LWIT_OFS_CTRL, 0);
        chk(q, 0, "ctrl rst");
        $display("test reset done");
        stop_test();
    end
endmodule // test_long_write_interrupt_termination
`default_nettype wire
